// file: shared/bsi_cfg.svh
// Contract
// [R1] Write data is captured on rising edges of both input strobes during a write.
// [R2] Write select low, sampled at the positive strobe rise, starts a write; the code ignores it while the write buffer is full.
// [R3] Write select high deselects the write port and its data is ignored.
// [R4] Each lane mask is sampled on the same strobe edge as its data word.
// [R5] Mask bit 0 covers data bits 8..0, bit 1 covers bits 17..9.
// [R6] A lane whose mask is high is not stored; memory keeps its old value.
// [R7] The shared address bus is sampled on positive strobe rises for both ports.
// [R8] Address is 18 bits; each address spans four burst locations.
// [R9] The address is ignored when the port owning that cycle is deselected.
// [R10] Read data is driven on rising edges of both input strobes.
// [R11] Read select low, sampled at the positive strobe rise, starts a read.
// [R12] Read deselect lets a burst finish; drivers release after next positive rise.
// [R13] Every read delivers four transfers from sequential locations.
// [R14] Valid flag is high while read data is valid, aligned with echo strobes.
// [R15] Every access starts on a rising edge of the positive input strobe.
// [R16] Echo strobes run freely, following the input strobes.
// [R17] A write moves four data words with masks on the following strobe rises.
// [R18] Read data starts 2.5 strobe cycles after request; valid spans four beats.
`ifndef BSI_CFG_SVH
`define BSI_CFG_SVH
// ****************************************************************
// widths and counts
// ****************************************************************
`define BSI_DW 18
`define BSI_AW 18
`define BSI_LN 2
`define BSI_LANE_W 9
`define BSI_BURST 4
`define BSI_MA 20
`define BSI_RD_LAT_HALF 5
`define BSI_PIPE_LEN 9
`define BSI_WR_ADDR_BEAT 1
`define BSI_FIFO_DEPTH 32
`define BSI_RST_OE 1'b0
`endif

// file: shared/bsi_pkg.sv
`default_nettype none
`include "bsi_cfg.svh"
package bsi_pkg;
  // ****************************************************************
  // pin bundle, read pipe slot, write burst
  // ****************************************************************
  typedef struct packed {
    logic wps_n;
    logic rps_n;
    logic [`BSI_AW-1:0] addr;
    logic [`BSI_DW-1:0] d;
    logic [`BSI_LN-1:0] bws_n;
  } bsi_pins_t;

  typedef struct packed {
    logic vld;
    logic [`BSI_AW-1:0] addr;
  } bsi_rd_t;

  typedef struct packed {
    logic [`BSI_AW-1:0] addr;
    logic [`BSI_BURST-1:0][`BSI_DW-1:0] data;
    logic [`BSI_BURST-1:0][`BSI_LN-1:0] mask_n;
  } bsi_wburst_t;

  typedef logic [$bits(bsi_wburst_t)-1:0] bsi_wword_t;
endpackage : bsi_pkg
`default_nettype wire

// file: verilog/bsi_fifo.sv
`default_nettype none
module bsi_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } bsi_fifo_st_t;
  bsi_fifo_st_t s, n;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;

  // flags straight from the count; the count is one bit wider so full and empty differ
  assign in_ready = (s.cnt < (AW+1)'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data = mem[s.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    n = s;
    if (push) n.wp = s.wp + AW'(1);
    if (pop) n.rp = s.rp + AW'(1);
    n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) s <= '0;
    else s <= n;
  end

  // storage has no reset, only the pointers and the count do
  always_ff @(posedge clk) begin
    if (push) mem[s.wp] <= in_data;
  end

  a_fifo_full: assert property (@(posedge clk) disable iff (!resetn)
    (s.cnt == (AW+1)'(DEPTH)) |-> !in_ready) else $error("fifo full but ready");
  a_fifo_count: assert property (@(posedge clk) disable iff (!resetn)
    (push && !pop) |=> (s.cnt == $past(s.cnt) + (AW+1)'(1))) else $error("fifo count slip");
endmodule : bsi_fifo
`default_nettype wire

// file: verilog/bsi_mem.sv
`default_nettype none
`include "bsi_cfg.svh"
module bsi_mem
  import bsi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // read port, one cycle latency, data held until next read
  input wire logic rd_en,
  input wire logic [`BSI_MA-1:0] raddr,
  output logic [`BSI_DW-1:0] rdata,
  // write port with lane enables
  input wire logic we,
  input wire logic [`BSI_MA-1:0] waddr,
  input wire logic [`BSI_DW-1:0] wdata,
  input wire logic [`BSI_LN-1:0] lane_en
);
  typedef struct packed {
    logic [`BSI_DW-1:0] rdata;
  } bsi_mem_st_t;
  bsi_mem_st_t s, n;
  logic [`BSI_DW-1:0] arr [2**`BSI_MA];

  assign rdata = s.rdata;

  always_comb begin
    n = s;
    if (rd_en) n.rdata = arr[raddr];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) s <= '0;
    else s <= n;
  end

  // masked lanes are simply not touched
  always_ff @(posedge clk) begin
    for (int l = 0; l < `BSI_LN; l++) begin
      if (we && lane_en[l]) begin
        arr[waddr][l*`BSI_LANE_W +: `BSI_LANE_W] <= wdata[l*`BSI_LANE_W +: `BSI_LANE_W]; // [R5]
      end
    end
  end

  a_lane_store: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    (we && lane_en[1]) |=> (arr[$past(waddr)][17:9] == $past(wdata[17:9])))
    else $error("enabled lane not stored");
  a_lane_keep: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    (we && !lane_en[0]) |=> (arr[$past(waddr)][8:0] == $past(arr[waddr][8:0])))
    else $error("masked lane changed");
endmodule : bsi_mem
`default_nettype wire

// file: verilog/bsi_sram_if.sv
`default_nettype none
`include "bsi_cfg.svh"
module bsi_sram_if
  import bsi_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // input strobes from the controller
  input wire logic input_strobe_pos,
  input wire logic input_strobe_neg,
  // port selects and shared address
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [`BSI_AW-1:0] pointer_input,
  // write data and lane masks
  input wire logic [`BSI_DW-1:0] write_input_bus,
  input wire logic [`BSI_LN-1:0] byte_lane_write_mask_n,
  // read data, driver enable and valid flag
  output logic [`BSI_DW-1:0] read_output_bus,
  output logic read_output_oe,
  output logic read_data_valid_flag,
  // echo strobes
  output logic echo_strobe_pos,
  output logic echo_strobe_neg,
  // write buffer has room for a new burst
  output logic write_buffer_ready
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic k_s1;
    logic k_s2;
    logic k_s3;
    logic kn_s1;
    logic kn_s2;
    logic kn_s3;
    bsi_pins_t in_s1;
    bsi_pins_t in_s2;
    bsi_rd_t [`BSI_PIPE_LEN-1:0] rd_pipe;
    logic [`BSI_DW-1:0] q_r;
    logic oe_r;
    logic vld_r;
    logic echo_p_r;
    logic echo_n_r;
    logic wbr_r;
    logic wr_act;
    logic [2:0] wr_beat;
    bsi_wburst_t wr_burst;
    logic wr_push;
    logic dr_busy;
    logic [1:0] dr_beat;
    bsi_wburst_t dr_cur;
  } bsi_st_t;

  bsi_st_t s, n;
  logic k_rise, kn_rise, evt;
  logic rd_en, we;
  logic [`BSI_MA-1:0] raddr, waddr;
  logic [`BSI_DW-1:0] rdata, wdata;
  logic [`BSI_LN-1:0] lane_en;
  logic fifo_in_ready, fifo_out_valid;
  bsi_wword_t fifo_out_data;
  bsi_wburst_t fifo_out;
  logic fetch_hit, drive_hit;
  logic [3:0] fetch_age, drive_age;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // oldest pending read whose age lies in lo..lo+3; returns hit and age
  function automatic logic [4:0] pick_age(input bsi_rd_t [`BSI_PIPE_LEN-1:0] p,
                                          input logic [3:0] lo);
    logic [4:0] r;
    r = '0;
    for (int i = 0; i < `BSI_BURST; i++) begin
      if (p[lo + 4'(i)].vld) r = {1'b1, lo + 4'(i)};
    end
    return r;
  endfunction : pick_age

  // lane masks are active low, the array wants enables
  function automatic logic [`BSI_LN-1:0] lanes_on(input logic [`BSI_LN-1:0] m_n);
    return ~m_n;
  endfunction : lanes_on

  // ****************************************************************
  // strobe edges
  // ****************************************************************
  // edges are taken from the second and third stages only
  assign k_rise = s.k_s2 && !s.k_s3; // [R15]
  assign kn_rise = s.kn_s2 && !s.kn_s3;
  assign evt = k_rise || kn_rise;

  // read scheduling looks at the pipe as it will stand after this event
  always_comb begin
    bsi_rd_t [`BSI_PIPE_LEN-1:0] np;
    np = s.rd_pipe;
    if (evt) begin
      for (int i = `BSI_PIPE_LEN-1; i > 0; i--) np[i] = s.rd_pipe[i-1];
      np[0] = '0;
      if (k_rise && !s.in_s2.rps_n) np[0] = '{vld: 1'b1, addr: s.in_s2.addr}; // [R11] [R7] [R9]
    end
    {fetch_hit, fetch_age} = pick_age(np, 4'(`BSI_RD_LAT_HALF - 1));
    {drive_hit, drive_age} = pick_age(np, 4'(`BSI_RD_LAT_HALF));
  end

  // one word is fetched per strobe event, a half period ahead of its beat
  assign rd_en = evt && fetch_hit; // [R13]
  always_comb begin
    logic [3:0] src;
    src = fetch_age - 4'(1);
    raddr = '0;
    if (fetch_hit) begin
      raddr = {s.rd_pipe[src].addr, 2'(fetch_age - 4'(`BSI_RD_LAT_HALF - 1))}; // [R8] [R13]
    end
  end

  // reads own the array port; the write drain waits a cycle when they meet
  assign we = s.dr_busy && !rd_en;
  assign waddr = {s.dr_cur.addr, s.dr_beat};
  assign wdata = s.dr_cur.data[s.dr_beat];
  assign lane_en = lanes_on(s.dr_cur.mask_n[s.dr_beat]); // [R6]

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n = s;
    // two flops on every pin before anything looks at it
    n.k_s1 = input_strobe_pos;
    n.k_s2 = s.k_s1;
    n.k_s3 = s.k_s2;
    n.kn_s1 = input_strobe_neg;
    n.kn_s2 = s.kn_s1;
    n.kn_s3 = s.kn_s2;
    n.in_s1 = '{wps_n: write_port_select_n, rps_n: read_port_select_n,
                addr: pointer_input, d: write_input_bus, bws_n: byte_lane_write_mask_n};
    n.in_s2 = s.in_s1;
    // echoes follow the synced strobes, so data updates land on their edges
    n.echo_p_r = s.k_s2; // [R16]
    n.echo_n_r = s.kn_s2; // [R16]
    n.wbr_r = fifo_in_ready;
    n.wr_push = 1'b0;

    if (evt) begin
      // read pipe ages by one half strobe cycle per event
      for (int i = `BSI_PIPE_LEN-1; i > 0; i--) n.rd_pipe[i] = s.rd_pipe[i-1];
      n.rd_pipe[0] = '0;
      if (k_rise && !s.in_s2.rps_n) begin
        n.rd_pipe[0] = '{vld: 1'b1, addr: s.in_s2.addr}; // [R11] [R7]
      end
      // output beats on both strobe edges, word fetched on the event before
      if (drive_hit) begin
        n.q_r = rdata; // [R10]
        n.vld_r = 1'b1; // [R14] [R18]
        n.oe_r = 1'b1;
      end else begin
        n.vld_r = 1'b0; // [R14]
        if (k_rise) n.oe_r = 1'b0; // [R12]
      end

      // write beats: data and masks on each of the four events after the request
      if (s.wr_act) begin
        n.wr_burst.data[s.wr_beat[1:0]] = s.in_s2.d; // [R1] [R17]
        n.wr_burst.mask_n[s.wr_beat[1:0]] = s.in_s2.bws_n; // [R4]
        if (k_rise && s.wr_beat == 3'(`BSI_WR_ADDR_BEAT)) begin
          n.wr_burst.addr = s.in_s2.addr; // [R7]
        end
        n.wr_beat = s.wr_beat + 3'(1);
        if (s.wr_beat == 3'(`BSI_BURST - 1)) begin
          n.wr_act = 1'b0;
          n.wr_push = 1'b1; // [R17]
        end
      end
      // a deselected write port leaves data and address unseen
      if (k_rise && !s.in_s2.wps_n && fifo_in_ready) begin
        n.wr_act = 1'b1; // [R2] [R3] [R15]
        n.wr_beat = '0;
      end
    end

    // drain: take one burst from the buffer, write its four words in order
    if (!s.dr_busy && fifo_out_valid) begin
      n.dr_busy = 1'b1;
      n.dr_beat = '0;
      n.dr_cur = fifo_out;
    end else if (we) begin
      n.dr_beat = s.dr_beat + 2'(1);
      if (s.dr_beat == 2'(`BSI_BURST - 1)) n.dr_busy = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) s <= '0;
    else s <= n;
  end

  // ****************************************************************
  // outputs and submodules
  // ****************************************************************
  assign read_output_bus = s.q_r;
  assign read_output_oe = s.oe_r;
  assign read_data_valid_flag = s.vld_r;
  assign echo_strobe_pos = s.echo_p_r;
  assign echo_strobe_neg = s.echo_n_r;
  assign write_buffer_ready = s.wbr_r;
  assign fifo_out = bsi_wburst_t'(fifo_out_data);

  // a burst arriving while the buffer is full is dropped; requests are
  // refused earlier while full, so that only happens on a late fill
  bsi_fifo #(
    .W($bits(bsi_wburst_t)),
    .DEPTH(`BSI_FIFO_DEPTH)
  ) u_wbuf (
    .clk(ref_clk),
    .resetn(resetn),
    .in_valid(s.wr_push),
    .in_ready(fifo_in_ready),
    .in_data(bsi_wword_t'(s.wr_burst)),
    .out_valid(fifo_out_valid),
    .out_ready(!s.dr_busy),
    .out_data(fifo_out_data)
  );

  // reads see only drained writes; a read right behind a write may be stale
  bsi_mem u_mem (
    .clk(ref_clk),
    .resetn(resetn),
    .rd_en(rd_en),
    .raddr(raddr),
    .rdata(rdata),
    .we(we),
    .waddr(waddr),
    .wdata(wdata),
    .lane_en(lane_en)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_rd_take;
    k_rise && !s.in_s2.rps_n;
  endsequence
  sequence s_burst_start;
    $rose(s.vld_r) && s.rd_pipe[`BSI_RD_LAT_HALF].vld;
  endsequence

  a_rd_take: assert property (s_rd_take |=> s.rd_pipe[0].vld) // [R11]
    else $error("read request not taken");
  a_rd_first: assert property ($rose(s.vld_r) |-> s_burst_start) // [R18]
    else $error("valid rose off the latency slot");
  a_rd_last: assert property ($fell(s.vld_r) |-> $past(s.rd_pipe[`BSI_PIPE_LEN-1].vld)) // [R13]
    else $error("valid fell before four beats");
  a_oe_release: assert property ($fell(s.oe_r) |-> $past(k_rise) && !s.vld_r) // [R12]
    else $error("driver released off a positive strobe");
  a_valid_oe: assert property (s.vld_r |-> s.oe_r) // [R14]
    else $error("valid without driver enable");
  a_valid_echo: assert property ($changed(s.vld_r) |-> // [R14]
    ($changed(s.echo_p_r) || $changed(s.echo_n_r)))
    else $error("valid moved off an echo edge");
  a_echo_track: assert property (k_rise |=> $rose(s.echo_p_r)) // [R16]
    else $error("echo missed a strobe rise");
  // a gapless next request may restart the beat count at the push, so look back
  a_wr_beats: assert property (s.wr_push |-> // [R17]
    $past(s.wr_act) && $past(s.wr_beat) == 3'(`BSI_BURST - 1))
    else $error("write burst pushed without four beats");
  a_port_share: assert property ((s.dr_busy && rd_en) |=> $stable(s.dr_beat)) // [R13]
    else $error("drain advanced over a read fetch");
  a_wr_ignore: assert property ((k_rise && s.in_s2.wps_n && !s.wr_act) |=> !s.wr_act) // [R3]
    else $error("deselected write port started a burst");
endmodule : bsi_sram_if
`default_nettype wire

// file: bench/bsi_ctl_model.sv
`default_nettype none
`include "bsi_cfg.svh"
module bsi_ctl_model
  import bsi_pkg::*;
(
  // timing reference
  input wire logic ref_clk,
  // strobes and request pins
  output logic strobe_pos,
  output logic strobe_neg,
  output bsi_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // strobes and pin events
  // ****
  int pev_cnt = 0;
  logic [`BSI_DW-1:0] pend_d = '0;
  logic [`BSI_LN-1:0] pend_m = '1;
  // strobes run free; the odd offset keeps them off ref_clk edges
  initial begin
    strobe_pos = 1'b0;
    pins = '1;
    #13;
    forever #100 strobe_pos = ~strobe_pos;
  end
  assign strobe_neg = ~strobe_pos;
  // every pin strobe rise is counted, for latency checks
  always @(posedge strobe_pos or posedge strobe_neg) begin
    pev_cnt <= pev_cnt + 1;
  end
  // ****
  // access slots
  // ****
  // pins change mid half-period so each rise sees settled values
  task automatic half();
    @(posedge strobe_pos or posedge strobe_neg);
    repeat (2) @(posedge ref_clk);
  endtask : half
  // park in the half period that precedes a positive rise
  task automatic align();
    @(posedge strobe_neg);
    repeat (2) @(posedge ref_clk);
  endtask : align
  // two strobe cycles: requests on the first positive rise, write address on
  // the second; the last write beat shares the next slot's request rise
  task automatic slot(input logic rd, input logic [`BSI_AW-1:0] ra, input logic wr,
      input bsi_wburst_t wb);
    pins.rps_n <= ~rd;
    pins.wps_n <= ~wr;
    pins.addr <= ra;
    pins.d <= pend_d;
    pins.bws_n <= pend_m;
    half();
    pins.rps_n <= 1'b1;
    pins.wps_n <= 1'b1;
    pins.addr <= ~ra;
    pins.d <= wb.data[0];
    pins.bws_n <= wb.mask_n[0];
    half();
    pins.addr <= wb.addr;
    pins.d <= wb.data[1];
    pins.bws_n <= wb.mask_n[1];
    half();
    pins.d <= wb.data[2];
    pins.bws_n <= wb.mask_n[2];
    half();
    pend_d = wb.data[3];
    pend_m = wb.mask_n[3];
  endtask : slot
endmodule : bsi_ctl_model
`default_nettype wire

// file: bench/bsi_sram_if_bench.sv
`default_nettype none
`include "bsi_cfg.svh"
module bsi_sram_if_bench
  import bsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic strobe_pos;
  logic strobe_neg;
  bsi_pins_t pins;
  logic [`BSI_DW-1:0] rdata;
  logic oe;
  logic vld;
  logic echo_p;
  logic echo_n;
  logic wb_rdy;
  int n_mismatch = 0;
  int n_checks = 0;
  int beat = 0;
  int echo_rises = 0;
  int e0;
  logic [`BSI_DW-1:0] mem [logic [`BSI_AW+1:0]];
  logic [`BSI_DW-1:0] exp_q [$];
  int lat_q [$];
  logic [`BSI_AW-1:0] pool [8];
  logic [`BSI_AW-1:0] last_wa = '0;
  // 40 MHz system clock
  always #12.5 ref_clk = ~ref_clk;
  bsi_ctl_model ctl (.ref_clk(ref_clk), .strobe_pos(strobe_pos), .strobe_neg(strobe_neg),
    .pins(pins));
  bsi_sram_if dut (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .input_strobe_pos(strobe_pos),
    .input_strobe_neg(strobe_neg),
    .write_port_select_n(pins.wps_n),
    .read_port_select_n(pins.rps_n),
    .pointer_input(pins.addr),
    .write_input_bus(pins.d),
    .byte_lane_write_mask_n(pins.bws_n),
    .read_output_bus(rdata),
    .read_output_oe(oe),
    .read_data_valid_flag(vld),
    .echo_strobe_pos(echo_p),
    .echo_strobe_neg(echo_n),
    .write_buffer_ready(wb_rdy)
  );
  // ****
  // checking helpers
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  // a lane with its mask high keeps the old content
  function automatic logic [`BSI_DW-1:0] lane_mix(input logic [`BSI_DW-1:0] old,
      input logic [`BSI_DW-1:0] nw, input logic [`BSI_LN-1:0] m_n);
    lane_mix = old;
    for (int l = 0; l < `BSI_LN; l++) begin
      if (!m_n[l]) lane_mix[l*`BSI_LANE_W +: `BSI_LANE_W] = nw[l*`BSI_LANE_W +: `BSI_LANE_W];
    end
  endfunction : lane_mix
  // one slot; reads avoid bursts that may still sit in the write buffer
  task automatic run_slot(input logic rd, input logic wr, input logic full, input int wi);
    bsi_wburst_t wb;
    logic [`BSI_AW-1:0] ra;
    logic [`BSI_AW+1:0] k;
    wb.addr = pool[wi < 0 ? $urandom_range(7) : wi];
    for (int i = 0; i < `BSI_BURST; i++) begin
      wb.data[i] = `BSI_DW'($urandom);
      wb.mask_n[i] = full ? '0 : `BSI_LN'($urandom);
    end
    do ra = pool[$urandom_range(7)]; while (ra == wb.addr || ra == last_wa);
    if (rd) begin
      lat_q.push_back(ctl.pev_cnt + 1);
      for (int i = 0; i < `BSI_BURST; i++) exp_q.push_back(mem[{ra, 2'(i)}]);
    end
    if (wr) begin
      chk(wb_rdy, 1'b1, "buffer ready");
      for (int i = 0; i < `BSI_BURST; i++) begin
        k = {wb.addr, 2'(i)};
        mem[k] = lane_mix(mem.exists(k) ? mem[k] : '0, wb.data[i], wb.mask_n[i]);
      end
      last_wa = wb.addr;
    end
    ctl.slot(rd, ra, wr, wb);
  endtask : run_slot
  // ****
  // monitors and sequence
  // ****
  always @(posedge echo_p) begin
    echo_rises++;
  end
  // each beat is sampled mid-way, two ref_clk cycles after its echo rise
  always @(posedge echo_p or posedge echo_n) begin
    int ev;
    ev = ctl.pev_cnt;
    repeat (2) @(posedge ref_clk);
    if (exp_q.size() == 0 || (beat == 0 && ev - lat_q[0] < 5)) begin
      chk(vld, 1'b0, "valid outside burst");
    end else begin
      if (beat == 0) chk(ev - lat_q.pop_front(), 5, "read latency");
      chk(vld, 1'b1, "valid in burst");
      chk(rdata, exp_q.pop_front(), "read beat");
      chk(oe, 1'b1, "driver on");
      beat = (beat + 1) % 4;
    end
  end
  initial begin
    void'($urandom(2));
    foreach (pool[i]) pool[i] = `BSI_AW'($urandom);
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ctl.align();
    // whole-burst writes give every pool entry known contents
    for (int i = 0; i < 8; i++) run_slot(1'b0, 1'b1, 1'b1, i);
    $display("test fill done");
    for (int i = 0; i < 8; i++) run_slot(1'b1, 1'b0, 1'b0, -1);
    $display("test gapless reads done");
    for (int i = 0; i < 120; i++) run_slot(1'($urandom), 1'($urandom), 1'b0, -1);
    $display("test random mix done");
    repeat (3) run_slot(1'b0, 1'b0, 1'b0, -1);
    chk(oe, 1'b0, "driver released");
    chk(exp_q.size(), 0, "beats missing");
    e0 = echo_rises;
    repeat (10) @(posedge strobe_pos);
    repeat (6) @(posedge ref_clk);
    chk(echo_rises - e0, 10, "echo rises");
    $display("test idle done");
    conclude();
  end
  // the run needs about 60 us; this cuts a hang short
  initial begin
    #400000;
    n_mismatch++;
    $display("FAIL at %0t: watchdog expired", $time);
    conclude();
  end
endmodule : bsi_sram_if_bench
`default_nettype wire
